// ### src/tsc_dev.sv
/*
  Converter end of the touch link: command receiver, acquire/hold/convert
  sequencer, result shifter and power/reference control outputs.
  Assumes the serial pins are asynchronous to sys_clk_i and slow enough
  (several system clocks per phase) for the three-flop synchroniser;
  sample_i is the held analog result, valid from the end of acquisition.
*/
module tsc_dev
  import tsc_pkg::*;
(
  input  wire logic        sys_clk_i,     // system clock
  input  wire logic        arst_n_i,      // async reset, active low
  tsc_if.dev               link,          // serial pins
  input  wire logic [11:0] sample_i,      // held input, binary code
  output logic      [2:0]  channel_o,     // active channel
  output logic             res8_o,        // eight-bit conversion
  output logic             diff_ref_o,    // ratiometric reference
  output logic             divider_en_o,  // battery divider on
  output logic             hold_o,        // sample-and-hold in hold
  output logic             drivers_on_o,  // touch drivers on
  output logic             busy_o,        // busy indication
  output logic             adc_pwr_o,     // converter powered
  output logic             ref_pwr_o,     // internal reference powered
  output logic             pen_irq_en_o,  // pen interrupt enabled
  output logic             ym_sw_o        // y-minus switch on in sleep
);
  logic [2:0]  pin_q;
  logic [2:0]  pin_rise;
  logic [2:0]  pin_fall;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_n_s;
  logic        din_s;
  logic        sel;

  logic [7:0]  rx_q;
  logic [3:0]  rx_cnt_q;
  logic        rx_take;
  logic        rx_start;
  logic        rx_shift;
  logic        rx_done;
  logic [7:0]  rx_byte;
  logic        pend_q;
  logic [7:0]  pend_cmd_q;

  tsc_seq_t    state_q;
  tsc_seq_t    state_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [4:0]  cnt_inc;
  logic [7:0]  cmd_q;
  logic        seq_start;
  logic        acq_end;
  logic        conv_end;
  logic        flush_end;
  logic [4:0]  conv_clks;
  logic        res8_w;
  logic        diff_w;

  logic        busy_q;
  logic        ref_pwr_q;
  logic [1:0]  pd_q;
  logic [11:0] res_q;
  logic        dout_q;

  tsc_sync #(
    .W    (3),
    .INIT (PIN_INIT)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       ({link.serial_clock, link.cs_n, link.din}),
    .q_o       (pin_q),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  assign sclk_rise = pin_rise[2];
  assign sclk_fall = pin_fall[2];
  assign cs_n_s    = pin_q[1];
  assign din_s     = pin_q[0];
  assign sel       = ~cs_n_s;

  // command receiver, one bit per rising serial edge
  assign rx_take  = sclk_rise & sel;
  assign rx_start = rx_take & (rx_cnt_q == 4'h0) & din_s & ~pend_q;
  assign rx_shift = rx_take & (rx_cnt_q != 4'h0);
  assign rx_done  = rx_shift & (rx_cnt_q == 4'h7);
  assign rx_byte  = {rx_q[6:0], din_s};

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_q     <= 8'h00;
      rx_cnt_q <= 4'h0;
    end else if (cs_n_s) begin
      rx_cnt_q <= 4'h0;
    end else if (rx_start) begin
      rx_q     <= 8'h01;
      rx_cnt_q <= 4'h1;
    end else if (rx_shift) begin
      rx_q     <= rx_byte;
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // a byte finished during readout waits here; one slot is enough because
  // the next start bit is refused until this one is taken
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q     <= 1'b0;
      pend_cmd_q <= 8'h00;
    end else begin
      pend_q     <= sel & (rx_done | (pend_q & ~seq_start));
      if (rx_done) begin
        pend_cmd_q <= rx_byte;
      end
    end
  end

  // sequencer decode
  assign res8_w    = cmd_q[RES_BIT];
  assign diff_w    = ~cmd_q[REF_BIT];
  assign conv_clks = tsc_conv_clks(res8_w, diff_w);
  assign cnt_inc   = cnt_q + 5'h01;
  // starting straight out of the trailing clocks lets commands overlap readout
  assign seq_start = pend_q & sel & ((state_q == S_IDLE) | (state_q == S_FLUSH));
  assign acq_end   = (state_q == S_ACQ) & sclk_rise & (cnt_inc == ACQ_CLKS);
  assign conv_end  = (state_q == S_CONV) & sclk_rise & (cnt_inc == conv_clks);
  assign flush_end = (state_q == S_FLUSH) & sclk_rise & (cnt_inc == FLUSH_CLKS);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE: begin
        if (seq_start) begin
          state_d = S_ACQ;
          cnt_d   = 5'h00;
        end
      end
      S_ACQ: begin
        if (acq_end) begin
          state_d = S_CONV;
          cnt_d   = 5'h00;
        end else if (sclk_rise) begin
          cnt_d = cnt_inc;
        end
      end
      S_CONV: begin
        if (conv_end) begin
          state_d = S_FLUSH;
          cnt_d   = 5'h00;
        end else if (sclk_rise) begin
          cnt_d = cnt_inc;
        end
      end
      S_FLUSH: begin
        if (seq_start) begin
          state_d = S_ACQ;
          cnt_d   = 5'h00;
        end else if (flush_end) begin
          state_d = S_IDLE;
          cnt_d   = 5'h00;
        end else if (sclk_rise) begin
          cnt_d = cnt_inc;
        end
      end
      default: begin
        state_d = S_IDLE;
        cnt_d   = 5'h00;
      end
    endcase
    if (cs_n_s) begin
      state_d = S_IDLE;
      cnt_d   = 5'h00;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= S_IDLE;
      cnt_q   <= 5'h00;
      cmd_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (seq_start) begin
        cmd_q <= pend_cmd_q;
      end
    end
  end

  // busy rises with hold and stands until the next falling serial edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q    <= 1'b0;
      ref_pwr_q <= REF_RESET;
      pd_q      <= PD_RESET;
    end else if (cs_n_s) begin
      busy_q <= 1'b0;                     // reference keeps its state
    end else if (acq_end) begin
      busy_q    <= 1'b1;
      ref_pwr_q <= cmd_q[PD1_BIT];
      pd_q      <= cmd_q[PD1_BIT:PD0_BIT];
    end else if (sclk_fall) begin
      busy_q <= 1'b0;
    end
  end

  // result shifter: the code is passed on, low four bits cleared in eight-bit mode, msb first on falling
  // edges; past both synchronisers the host samples each bit on the second rising edge after
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_q  <= 12'h000;
      dout_q <= 1'b0;
    end else if (cs_n_s) begin
      dout_q <= 1'b0;
    end else if (acq_end) begin
      res_q <= res8_w ? {sample_i[11:4], 4'h0} : sample_i;
    end else if (sclk_fall) begin
      if (state_q == S_CONV) begin
        dout_q <= res_q[11];
        res_q  <= {res_q[10:0], 1'b0};
      end else begin
        dout_q <= 1'b0;
      end
    end
  end

  assign link.dout      = dout_q;
  assign link.dout_oe_n = cs_n_s;

  assign channel_o    = cmd_q[CH_HI:CH_LO];
  assign res8_o       = res8_w;
  assign diff_ref_o   = diff_w;
  assign busy_o       = busy_q;
  assign hold_o       = (state_q == S_CONV);
  assign divider_en_o = (state_q == S_ACQ) & (channel_o == CH_BATTERY);
  // ratiometric needs the panel powered while the comparator decides
  assign drivers_on_o = (state_q == S_ACQ) | ((state_q == S_CONV) & diff_w);
  // converter wakes with the sequence itself, so no settle delay is needed
  assign adc_pwr_o    = sel & ((state_q != S_IDLE) | pd_q[PD0_BIT]);
  assign ref_pwr_o    = ref_pwr_q;
  assign pen_irq_en_o = ~pd_q[PD0_BIT];
  assign ym_sw_o      = (pd_q == PD_RESET) & (state_q == S_IDLE);
endmodule : tsc_dev

// ### src/tsc_pkg.sv
/*
  Shared constants, types and helpers for the touch converter serial link:
  command byte layout, sequence lengths, host register map, state codes.
  Assumes a 10 MHz system clock on both ends and a serial clock that the
  host derives from it.
*/
package tsc_pkg;
  localparam int          SYS_PERIOD_NS  = 100;
  localparam int          SCLK_PERIOD_NS = 800;
  localparam int          HALF_CYC       = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [2:0]  HALF_LAST      = 3'(HALF_CYC - 1);
  localparam int          START_BIT      = 7;
  localparam int          CH_HI          = 6;
  localparam int          CH_LO          = 4;
  localparam int          RES_BIT        = 3;
  localparam int          REF_BIT        = 2;
  localparam int          PD1_BIT        = 1;
  localparam int          PD0_BIT        = 0;
  localparam logic [2:0]  CH_BATTERY     = 3'h2;
  localparam logic [4:0]  ACQ_CLKS       = 5'h03;
  localparam logic [4:0]  FULL_BITS      = 5'h0C;
  localparam logic [4:0]  SHORT_BITS     = 5'h08;
  localparam logic [4:0]  FLUSH_CLKS     = 5'h03;
  localparam logic [4:0]  FRAME_CLKS     = 5'h1B;
  localparam logic [4:0]  CAP_FIRST      = 5'h0C;
  localparam logic [4:0]  CAP_LAST       = 5'h17;
  localparam logic [1:0]  PD_RESET       = 2'h0;
  localparam logic        REF_RESET      = 1'h0;
  localparam logic [2:0]  PIN_INIT       = 3'h2;
  localparam logic [7:0]  RATIO_CH_MASK  = 8'hFF;
  localparam logic [3:0]  REG_CMD        = 4'h0;
  localparam logic [3:0]  REG_STAT       = 4'h4;
  localparam logic [3:0]  REG_RESULT     = 4'h8;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_ACQ   = 4'h2,
    S_CONV  = 4'h4,
    S_FLUSH = 4'h8
  } tsc_seq_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_LOW  = 3'h2,
    H_HIGH = 3'h4
  } tsc_frame_t;

  // serial clocks spent converting, including the ratiometric extra clock
  function automatic logic [4:0] tsc_conv_clks(input logic res8, input logic diff);
    tsc_conv_clks = (res8 ? SHORT_BITS : FULL_BITS) + {4'h0, diff};
  endfunction : tsc_conv_clks
endpackage : tsc_pkg

// ### src/tsc_if.sv
/*
  Serial link between host and converter: clock, select, data in, data out.
  Assumes the host drives clock, select and data in; the converter output
  is resolved here from its enable, reading low when released.
*/
interface tsc_if;
  logic serial_clock;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic dout_line;

  assign dout_line = dout_oe_n ? 1'b0 : dout;

  modport dev  (input serial_clock, input cs_n, input din, output dout, output dout_oe_n);
  modport host (output serial_clock, output cs_n, output din, input dout_line);
endinterface : tsc_if

// ### src/tsc_sync.sv
/*
  Three-flop pin synchroniser with agreement filter and edge pulses.
  Assumes inputs asynchronous to sys_clk_i; outputs are in its domain.
*/
module tsc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         sys_clk_i,  // system clock
  input  wire logic         arst_n_i,   // async reset, active low
  input  wire logic [W-1:0] d_i,        // raw pins
  output logic      [W-1:0] q_o,        // filtered level
  output logic      [W-1:0] rise_o,     // one-cycle rise pulse
  output logic      [W-1:0] fall_o      // one-cycle fall pulse
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // a change counts only once the second and third stage agree
  assign q_d    = (s2_q & s3_q) | (q_q & (s2_q ^ s3_q));
  assign q_o    = q_q;
  assign rise_o = q_d & ~q_q;
  assign fall_o = ~q_d & q_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_q  <= INIT;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end
endmodule : tsc_sync

// ### src/tsc_host.sv
/*
  Host end of the touch link: AXI4-Lite slave with command, status and
  result registers, and a framer that makes the serial clock by division.
  Assumes the converter answers on dout as the converter end does; one
  frame of fixed length carries one command and its twelve-bit result.
*/
module tsc_host
  import tsc_pkg::*;
(
  input  wire logic        sys_clk_i,         // system clock
  input  wire logic        arst_n_i,          // async reset, active low
  input  wire logic        s_axi_awvalid_i,   // write address valid
  output logic             s_axi_awready_o,   // write address ready
  input  wire logic [3:0]  s_axi_awaddr_i,    // write address
  input  wire logic        s_axi_wvalid_i,    // write data valid
  output logic             s_axi_wready_o,    // write data ready
  input  wire logic [31:0] s_axi_wdata_i,     // write data
  input  wire logic [3:0]  s_axi_wstrb_i,     // byte strobes
  output logic             s_axi_bvalid_o,    // write response valid
  input  wire logic        s_axi_bready_i,    // write response ready
  output logic      [1:0]  s_axi_bresp_o,     // write response
  input  wire logic        s_axi_arvalid_i,   // read address valid
  output logic             s_axi_arready_o,   // read address ready
  input  wire logic [3:0]  s_axi_araddr_i,    // read address
  output logic             s_axi_rvalid_o,    // read data valid
  input  wire logic        s_axi_rready_i,    // read data ready
  output logic      [31:0] s_axi_rdata_o,     // read data
  output logic      [1:0]  s_axi_rresp_o,     // read response
  tsc_if.host              link               // serial pins
);
  logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [3:0]  awaddr_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_data;
  logic        wr_go, rd_go, rd_map, wr_map, cmd_wr, frame_start;
  logic [7:0]  cmd_eff;
  tsc_frame_t  state_q, state_d;
  logic [2:0]  div_q;
  logic [4:0]  clk_cnt_q;
  logic        half_end, last_clk, capture;
  logic        sclk_q, cs_n_q, din_q, done_q;
  logic [6:0]  sh_q;
  logic [11:0] cap_q, result_q;
  logic [7:0]  last_cmd_q;
  logic        dout_s;

  tsc_sync #(
    .W    (1),
    .INIT (1'b0)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (link.dout_line),
    .q_o       (dout_s),
    .rise_o    (),
    .fall_o    ()
  );

  assign s_axi_awready_o = ~aw_full_q;
  assign s_axi_wready_o  = ~w_full_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_go   = s_axi_arvalid_i & ~rvalid_q;
  assign wr_map  = (awaddr_q == REG_CMD) | (awaddr_q == REG_STAT) | (awaddr_q == REG_RESULT);
  assign rd_map  = (s_axi_araddr_i == REG_CMD) | (s_axi_araddr_i == REG_STAT) |
                   (s_axi_araddr_i == REG_RESULT);
  assign rd_data = (s_axi_araddr_i == REG_CMD)  ? {24'h000000, last_cmd_q} :
                   (s_axi_araddr_i == REG_STAT) ? {30'h00000000, done_q, state_q != H_IDLE} :
                   (s_axi_araddr_i == REG_RESULT) ? {20'h00000, result_q} : 32'h00000000;
  // a command written mid-frame is dropped; software polls busy first
  assign cmd_wr      = wr_go & (awaddr_q == REG_CMD) & wlane_q;
  assign frame_start = cmd_wr & (state_q == H_IDLE);
  // ratiometric only where the mask allows it, else force single-ended
  assign cmd_eff = {wbyte_q[7:3], wbyte_q[REF_BIT] | ~RATIO_CH_MASK[wbyte_q[CH_HI:CH_LO]],
                    wbyte_q[1:0]};

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      aw_full_q <= ~wr_go & (aw_full_q | s_axi_awvalid_i);
      w_full_q  <= ~wr_go & (w_full_q | s_axi_wvalid_i);
      if (s_axi_awvalid_i & ~aw_full_q) begin
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & ~w_full_q) begin
        wbyte_q <= s_axi_wdata_i[7:0];
        wlane_q <= s_axi_wstrb_i[0];
      end
      bvalid_q <= wr_go | (bvalid_q & ~s_axi_bready_i);
      if (wr_go) begin
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      rvalid_q <= rd_go | (rvalid_q & ~s_axi_rready_i);
      if (rd_go) begin
        rdata_q <= rd_data;
        rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign half_end = (div_q == HALF_LAST);
  // frame covers command, acquisition, conversion and trailing clocks
  assign last_clk = (clk_cnt_q == FRAME_CLKS - 5'h01);
  assign capture  = (clk_cnt_q >= CAP_FIRST) & (clk_cnt_q <= CAP_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      H_IDLE: begin
        if (frame_start) begin
          state_d = H_LOW;
        end
      end
      H_LOW: begin
        if (half_end) begin
          state_d = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_end) begin
          state_d = last_clk ? H_IDLE : H_LOW;
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
  end

  // select rises between frames, so a reference-off command is its own frame
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q    <= H_IDLE;
      div_q      <= 3'h0;
      clk_cnt_q  <= 5'h00;
      sclk_q     <= 1'b0;
      cs_n_q     <= 1'b1;
      din_q      <= 1'b0;
      sh_q       <= 7'h00;
      cap_q      <= 12'h000;
      result_q   <= 12'h000;
      done_q     <= 1'b0;
      last_cmd_q <= 8'h00;
    end else begin
      state_q <= state_d;
      div_q   <= ((state_q == H_IDLE) | half_end) ? 3'h0 : div_q + 3'h1;
      if (frame_start) begin
        cs_n_q     <= 1'b0;
        din_q      <= cmd_eff[START_BIT];
        sh_q       <= cmd_eff[6:0];
        clk_cnt_q  <= 5'h00;
        done_q     <= 1'b0;
        last_cmd_q <= cmd_eff;
      end else if ((state_q == H_LOW) & half_end) begin
        sclk_q <= 1'b1;
        // both synchronisers delay each bit by one serial clock; taking it at
        // the rise keeps the sample half a clock away from either change
        if (capture) begin
          cap_q <= {cap_q[10:0], dout_s};
        end
      end else if ((state_q == H_HIGH) & half_end) begin
        sclk_q    <= 1'b0;
        din_q     <= sh_q[6];
        sh_q      <= {sh_q[5:0], 1'b0};
        clk_cnt_q <= clk_cnt_q + 5'h01;
        if (last_clk) begin
          cs_n_q   <= 1'b1;
          done_q   <= 1'b1;
          result_q <= cap_q;
        end
      end
    end
  end

  assign link.serial_clock = sclk_q;
  assign link.cs_n         = cs_n_q;
  assign link.din          = din_q;
endmodule : tsc_host

// ### dv/tsc_checker.sv
/*
  Checker for the host-converter link and converter sequencer.
  Assumes every input is sampled on the system clock.
*/
module tsc_checker
  import tsc_pkg::*;
(
  input wire logic       sys_clk_i,    // clock
  input wire logic       arst_n_i,     // reset
  input wire logic       serial_clock, // link clk
  input wire logic       cs_n,         // select
  input wire logic       din,          // data in
  input wire logic       dout_oe_n,    // enable
  input wire logic       dout_line,    // data out
  input wire logic [2:0] channel_o,    // channel
  input wire logic       res8_o,       // 8-bit
  input wire logic       diff_ref_o,   // ratio
  input wire logic       divider_en_o, // divider
  input wire logic       hold_o,       // hold
  input wire logic       drivers_on_o, // drivers
  input wire logic       busy_o,       // busy
  input wire logic       adc_pwr_o     // converter power
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt_q;
  logic res8_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // hold length in system clocks, 8 per serial clock; sync skew needs slack
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= 0;
      res8_q <= 1'b0;
    end else begin
      cnt_q  <= hold_o ? cnt_q + 1 : 0;
      res8_q <= (hold_o && cnt_q == 0) ? res8_o : res8_q;
    end
  end
  sequence s_left;
    $rose(cs_n) ##1 cs_n [*7];
  endsequence
  sequence s_conv_end;
    $fell(hold_o) && !cs_n;
  endsequence
  // busy stands from the hold edge to the next falling serial edge
  sequence s_busy_pulse;
    busy_o [*4] ##1 !busy_o;
  endsequence
  AST_BUSY_HOLD: assert property ($rose(busy_o) |-> $rose(hold_o))
    else $error("busy and hold apart");
  AST_BUSY_LEN: assert property ($rose(busy_o) |-> s_busy_pulse)
    else $error("busy length wrong");
  AST_ADC_PWR: assert property (hold_o |-> adc_pwr_o)
    else $error("converter off while converting");
  AST_DOUT_OFF: assert property (cs_n [*8] |-> dout_oe_n && !dout_line)
    else $error("output driven while deselected");
  AST_DIVIDER: assert property (divider_en_o |-> channel_o == CH_BATTERY && !hold_o)
    else $error("divider on wrongly");
  AST_DRIVERS: assert property (hold_o |-> drivers_on_o == diff_ref_o)
    else $error("drivers wrong in hold");
  AST_CONV_LEN: assert property (s_conv_end |-> (res8_q ? cnt_q inside {[56:80]} : cnt_q inside {[88:112]}))
    else $error("conversion length wrong");
  AST_TAIL_LOW: assert property (s_conv_end |-> ##12 !dout_line)
    else $error("output not low after result");
  AST_START: assert property ($fell(cs_n) |-> din)
    else $error("frame lacks start bit");
  AST_DIN_EDGE: assert property ($changed(din) && !cs_n |-> !serial_clock)
    else $error("data moved with clock high");
  AST_ABORT: assert property (s_left |-> !hold_o && !divider_en_o && !drivers_on_o)
    else $error("still active after deselect");
endmodule : tsc_checker

// ### dv/tsc_tb.sv
/*
  Bench: AXI4-Lite master into the host end, host and converter on one
  link with the checker beside it. Assumes offsets 0x0, 0x4, 0x8.
*/
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t %0h %0h", $time, g, e); end end
module tsc_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [33:0] MW = {2'h3, 32'h0};
  localparam logic [33:0] MA = '1;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [3:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0, s_axi_wstrb_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, r;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [11:0] sample_i = '0;
  logic [2:0]  channel_o;
  logic        res8_o, diff_ref_o, divider_en_o, hold_o, drivers_on_o, busy_o;
  logic        adc_pwr_o, ref_pwr_o, pen_irq_en_o, ym_sw_o;
  logic [33:0] exp_q[$], msk_q[$], got, m, e0;
  logic [7:0]  cmd;
  int          seed, num_errors, tests_run, n;

  tsc_if link ();
  tsc_host tsc_host_inst (.*);
  tsc_dev tsc_dev_inst (.*);
  tsc_checker tsc_checker_inst (.sys_clk_i, .arst_n_i, .serial_clock(link.serial_clock), .cs_n(link.cs_n),
    .din(link.din), .dout_oe_n(link.dout_oe_n), .dout_line(link.dout_line), .channel_o, .res8_o,
    .diff_ref_o, .divider_en_o, .hold_o, .drivers_on_o, .busy_o, .adc_pwr_o);

  always #50 sys_clk_i = ~sys_clk_i;

  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic hang;
    num_errors++;
    complete_run();
  endtask : hang

  // request held until its ready; response ready held until answered
  task automatic xf(input logic wr, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                    input logic [33:0] e, input logic [33:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{wr}};
    {s_axi_arvalid_i, s_axi_rready_i} <= {2{!wr}};
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, s_axi_wdata_i} <= {a, a, s, d};
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_bvalid_o && s_axi_bready_i || s_axi_rvalid_o && s_axi_rready_i) break;
    end
    {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
    if (n == 40) hang();
    // let an edge pass so the next call does not drive ready twice at once
    @(posedge sys_clk_i);
  endtask : xf

  always @(posedge sys_clk_i) begin
    if (s_axi_bvalid_o && s_axi_bready_i || s_axi_rvalid_o && s_axi_rready_i) begin
      got = s_axi_rvalid_o ? {s_axi_rresp_o, s_axi_rdata_o} : {s_axi_bresp_o, 32'h0};
      m = msk_q.pop_front();
      e0 = exp_q.pop_front();
      `CHK(got & m, e0 & m)
    end
  end

  initial begin
    seed = 64312;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      cmd = {1'b1, (i == 2) ? 3'h2 : r[2:0], i[0], i[1], i[1:0]};
      sample_i <= r[15:4];
      xf(1'b1, 4'h0, 4'hF, {24'h0, cmd}, 34'h0, MW);
      for (n = 0; n < 300 && !link.cs_n; n++) @(posedge sys_clk_i);
      if (n == 300) hang();
      @(posedge sys_clk_i);
      xf(1'b0, 4'h8, 4'h0, 32'h0, {22'h0, i[0] ? {r[15:8], 4'h0} : r[15:4]}, MA);
      xf(1'b0, 4'h4, 4'h0, 32'h0, 34'h2, MA);
      xf(1'b0, 4'h0, 4'h0, 32'h0, {26'h0, cmd}, MA);
      `CHK({channel_o, res8_o, diff_ref_o}, {cmd[6:3], !cmd[2]})
      `CHK({ref_pwr_o, pen_irq_en_o, ym_sw_o}, {cmd[1], !cmd[0], cmd[1:0] == 2'h0})
      $display("test cmd %0h done", cmd);
    end
    xf(1'b1, 4'hC, 4'hF, 32'h0, {2'h2, 32'h0}, MW);
    xf(1'b0, 4'hC, 4'h0, 32'h0, {2'h2, 32'h0}, MW);
    xf(1'b1, 4'h0, 4'h0, 32'h81, 34'h0, MW);
    repeat (8) @(posedge sys_clk_i);
    `CHK(link.cs_n, 1'b1)
    xf(1'b0, 4'h0, 4'h0, 32'h0, {26'h0, cmd}, MA);
    @(posedge sys_clk_i);
    $display("test register map done");
    complete_run();
  end
endmodule : tsc_tb
